/* tb/tb_queue_write_port_capture.sv */
// testbench for the write port capture block
`timescale 1ns/1ns
`include "wcap_defs.svh"
module tb_queue_write_port_capture
  import wcap_pkg::*;
;
  localparam logic [`WCAP_DATA_W-1:0] DA = 40'hA5C3F01E77;
  localparam logic [`WCAP_DATA_W-1:0] DB = 40'h5A3C0FE188;
  logic sys_clk, srst, write_clk, write_enable_n, write_chip_select_n;
  logic write_double_rate_select, master_reset_n;
  logic [`WCAP_DATA_W-1:0] write_data, word_data;
  logic word_valid, word_on_fall, double_rate_mode, in_master_reset;
  logic [`WCAP_DATA_W:0] words[$];
  int n_errors = 0;
  int checked = 0;
  int cycles = 0;
  // ****
  // clock, instances, monitor
  // ****
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  queue_write_port_capture queue_write_port_capture_inst (.sys_clk, .srst, .write_clk,
    .write_enable_n, .write_chip_select_n, .write_double_rate_select, .master_reset_n,
    .write_data, .word_valid, .word_data, .word_on_fall, .double_rate_mode, .in_master_reset);
  wsrc_model wsrc_model_inst (.sys_clk, .write_clk, .write_enable_n, .write_chip_select_n,
    .write_double_rate_select, .master_reset_n, .write_data);
  always @(posedge sys_clk) begin
    cycles <= cycles + 1;
    if (word_valid === 1'b1) words.push_back({word_on_fall, word_data});
    if (cycles == 3000) begin
      n_errors++;
      give_verdict();
    end
  end
  // ****
  // checks and scenarios
  // ****
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic expect_words(input int n, input logic [`WCAP_DATA_W:0] w0, w1);
    repeat (8) @(posedge sys_clk);
    check("word count", 64'(words.size()), 64'(n));
    if (n > 0 && words.size() > 0) check("first word", 64'(words[0]), 64'(w0));
    if (n > 1 && words.size() > 1) check("second word", 64'(words[1]), 64'(w1));
    words.delete();
  endtask : expect_words
  task automatic single_rate;
    wsrc_model_inst.mreset(RATE_SINGLE);
    check("mode", 64'(double_rate_mode), 64'(RATE_SINGLE));
    check("in reset", 64'(in_master_reset), 64'(0));
    wsrc_model_inst.burst(1'b0, 1'b0, DA, DB);
    expect_words(1, {1'b0, DA}, '0);
    wsrc_model_inst.burst(1'b1, 1'b0, DA, DB);
    expect_words(0, '0, '0);
    wsrc_model_inst.burst(1'b0, 1'b1, DA, DB);
    expect_words(0, '0, '0);
  endtask : single_rate
  task automatic double_rate;
    wsrc_model_inst.mreset(RATE_DOUBLE);
    check("mode", 64'(double_rate_mode), 64'(RATE_DOUBLE));
    wsrc_model_inst.burst(1'b0, 1'b0, DA, DB);
    expect_words(2, {1'b0, DA}, {1'b1, DB});
    wsrc_model_inst.burst(1'b1, 1'b0, DA, DB);
    expect_words(0, '0, '0);
    wsrc_model_inst.set_static(1'b0, 1'b1);
    wsrc_model_inst.burst(1'b0, 1'b0, DB, DA);
    expect_words(2, {1'b0, DB}, {1'b1, DA});
    check("mode", 64'(double_rate_mode), 64'(RATE_DOUBLE));
    wsrc_model_inst.set_static(1'b0, 1'b0);
    wsrc_model_inst.burst(1'b0, 1'b0, DA, DB);
    check("in reset", 64'(in_master_reset), 64'(1));
    expect_words(0, '0, '0);
    check("mode", 64'(double_rate_mode), 64'(RATE_SINGLE));
  endtask : double_rate
  task automatic give_verdict;
    if (n_errors == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict
  initial begin
    wsrc_model_inst.idle();
    srst = 1'b1;
    repeat (5) @(posedge sys_clk);
    srst <= 1'b0;
    single_rate();
    double_rate();
    give_verdict();
  end
endmodule : tb_queue_write_port_capture

/* tb/wsrc_model.sv */
// upstream write source model driving the write port pins
`timescale 1ns/1ns
`include "wcap_defs.svh"
module wsrc_model #(
  parameter int DATA_W = `WCAP_DATA_W
) (
  input wire logic sys_clk,
  output logic write_clk,
  output logic write_enable_n,
  output logic write_chip_select_n,
  output logic write_double_rate_select,
  output logic master_reset_n,
  output logic [DATA_W-1:0] write_data
);
  // ****
  // pin drive
  // ****
  // idle pin levels with master reset held
  task automatic idle;
    write_clk <= 1'b0;
    write_enable_n <= 1'b1;
    write_chip_select_n <= 1'b1;
    write_double_rate_select <= 1'b0;
    master_reset_n <= 1'b0;
    write_data <= '0;
  endtask : idle
  // static pins: rate select and master reset
  task automatic set_static(input logic rate, input logic mrst_n);
    write_double_rate_select <= rate;
    master_reset_n <= mrst_n;
  endtask : set_static
  task automatic hold(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : hold
  // master reset pulse, rate select steady around it
  task automatic mreset(input logic rate);
    write_double_rate_select <= rate;
    master_reset_n <= 1'b0;
    hold(8);
    master_reset_n <= 1'b1;
    hold(8);
  endtask : mreset
  // one write clock period, clock idles low between periods
  task automatic burst(input logic en_n, input logic cs_n, input logic [DATA_W-1:0] dr, df);
    write_enable_n <= en_n;
    write_chip_select_n <= cs_n;
    write_data <= dr;
    hold(4);
    write_clk <= 1'b1;
    hold(4);
    write_data <= df;
    hold(4);
    write_clk <= 1'b0;
    hold(4);
    write_enable_n <= 1'b1;
    write_chip_select_n <= 1'b1;
    write_data <= ~df;
    hold(1);
  endtask : burst
endmodule : wsrc_model

/* verilog/pin_edge_if.sv */
// synchronised write pins and detected write clock edges
`timescale 1ns/1ns
`include "wcap_defs.svh"
interface pin_edge_if #(
  parameter int DATA_W = `WCAP_DATA_W
);
  logic rise;
  logic fall;
  logic enable_n;
  logic chip_select_n;
  logic double_rate_select;
  logic master_reset_n;
  logic [DATA_W-1:0] data;

  modport src (
    output rise, fall, enable_n, chip_select_n, double_rate_select, master_reset_n, data
  );
  modport snk (
    input rise, fall, enable_n, chip_select_n, double_rate_select, master_reset_n, data
  );
endinterface : pin_edge_if

/* verilog/pin_sync.sv */
// two-flop synchroniser for the write pins and write clock edge detector
`timescale 1ns/1ns
`include "wcap_defs.svh"
module pin_sync
  import wcap_pkg::*;
#(
  parameter int DATA_W = `WCAP_DATA_W
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic write_clk,
  input wire logic write_enable_n,
  input wire logic write_chip_select_n,
  input wire logic write_double_rate_select,
  input wire logic master_reset_n,
  input wire logic [DATA_W-1:0] write_data,
  pin_edge_if.src pe
);
  localparam int VW = DATA_W + 5;
  localparam logic [VW-1:0] RST_V = {`WCAP_CLK_RST, `WCAP_EN_N_RST, `WCAP_EN_N_RST,
    `WCAP_MODE_RST, `WCAP_MRST_N_RST, {DATA_W{1'b0}}};

  // ************************************************************
  // three stages: two to synchronise, one to find edges
  // ************************************************************
  logic [VW-1:0] s1_q, s1_d, s2_q, s2_d, s3_q, s3_d;

  always_comb begin
    s1_d = {write_clk, write_enable_n, write_chip_select_n, write_double_rate_select,
      master_reset_n, write_data};
    s2_d = s1_q;
    s3_d = s2_q;
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s1_q <= RST_V;
      s2_q <= RST_V;
      s3_q <= RST_V;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

  // levels are taken from the stage just before the edge
  assign pe.rise = s2_q[VW-1] & ~s3_q[VW-1];
  assign pe.fall = ~s2_q[VW-1] & s3_q[VW-1];
  assign pe.enable_n = s3_q[VW-2];
  assign pe.chip_select_n = s3_q[VW-3];
  assign pe.double_rate_select = s3_q[VW-4];
  assign pe.master_reset_n = s3_q[VW-5];
  assign pe.data = s3_q[DATA_W-1:0];

endmodule : pin_sync

/* verilog/queue_write_port_capture.sv */
// write port capture: single or double rate word capture on the write clock
// Operation
// [RULE1] write activity follows write clock edges: rising only, or both in double rate
// [RULE2] rate select is taken during master reset and held until the next one
// [RULE3] rate 1 takes a word per rising and falling edge; rate 0 rising only
// [RULE4] a write needs enable and chip select both low at the rising edge
// [RULE5] upstream holds the rate select steady while the port operates
// [RULE6] levels seen at a rising edge also qualify the next falling edge word
`timescale 1ns/1ns
`include "wcap_defs.svh"
module queue_write_port_capture
  import wcap_pkg::*;
#(
  parameter int DATA_W = `WCAP_DATA_W
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic write_clk,
  input wire logic write_enable_n,
  input wire logic write_chip_select_n,
  input wire logic write_double_rate_select,
  input wire logic master_reset_n,
  input wire logic [DATA_W-1:0] write_data,
  output logic word_valid,
  output logic [DATA_W-1:0] word_data,
  output logic word_on_fall,
  output logic double_rate_mode,
  output logic in_master_reset
);

  if (DATA_W < 1) begin : g_width_check
    $error("DATA_W must be at least 1");
  end

  pin_edge_if #(.DATA_W(DATA_W)) pe ();

  pin_sync #(.DATA_W(DATA_W)) u_sync (
    .sys_clk(sys_clk),
    .srst(srst),
    .write_clk(write_clk),
    .write_enable_n(write_enable_n),
    .write_chip_select_n(write_chip_select_n),
    .write_double_rate_select(write_double_rate_select),
    .master_reset_n(master_reset_n),
    .write_data(write_data),
    .pe(pe.src)
  );

  // ************************************************************
  // rate latch and word capture
  // ************************************************************
  rate_t mode_q, mode_d;
  logic qual_q, qual_d;
  logic valid_q, valid_d;
  logic fall_q, fall_d;
  logic mrst_q, mrst_d;
  logic [DATA_W-1:0] data_q, data_d;

  always_comb begin
    mode_d = mode_q;
    qual_d = qual_q;
    valid_d = 1'b0;
    fall_d = fall_q;
    data_d = data_q;
    mrst_d = ~pe.master_reset_n;
    if (!pe.master_reset_n) begin
      mode_d = rate_t'(pe.double_rate_select); // RULE2
      qual_d = 1'b0;
    end else if (pe.rise) begin
      qual_d = ~pe.enable_n & ~pe.chip_select_n; // RULE4
      if (qual_d) begin
        valid_d = 1'b1; // RULE1
        fall_d = 1'b0;
        data_d = pe.data;
      end
    end else if (pe.fall && mode_q == RATE_DOUBLE && qual_q) begin
      valid_d = 1'b1; // RULE3 RULE6
      fall_d = 1'b1;
      data_d = pe.data;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      mode_q <= rate_t'(`WCAP_MODE_RST);
      qual_q <= 1'b0;
      valid_q <= 1'b0;
      fall_q <= 1'b0;
      mrst_q <= 1'b1;
      data_q <= '0;
    end else begin
      mode_q <= mode_d;
      qual_q <= qual_d;
      valid_q <= valid_d;
      fall_q <= fall_d;
      mrst_q <= mrst_d;
      data_q <= data_d;
    end
  end

  assign word_valid = valid_q;
  assign word_data = data_q;
  assign word_on_fall = fall_q;
  assign double_rate_mode = (mode_q == RATE_DOUBLE);
  assign in_master_reset = mrst_q;

  // ************************************************************
  // checks
  // ************************************************************
  sequence s_qual_rise;
    pe.rise && !pe.enable_n && !pe.chip_select_n && pe.master_reset_n;
  endsequence

  sequence s_rise_word;
    valid_q && !fall_q;
  endsequence

  property p_rise_write;
    @(posedge sys_clk) disable iff (srst)
    s_qual_rise |=> s_rise_word and (data_q == $past(pe.data));
  endproperty
  a_rise_write: assert property (p_rise_write) else $error("qualified rise lost"); // RULE4

  property p_unqual_rise;
    @(posedge sys_clk) disable iff (srst)
    pe.rise && (pe.enable_n || pe.chip_select_n) |=> !valid_q;
  endproperty
  a_unqual_rise: assert property (p_unqual_rise) else $error("unqualified write"); // RULE4

  property p_single_fall;
    @(posedge sys_clk) disable iff (srst)
    pe.fall && mode_q == RATE_SINGLE |=> !valid_q;
  endproperty
  a_single_fall: assert property (p_single_fall) else $error("fall word in single"); // RULE1

  sequence s_high_stretch;
    (!pe.fall && !pe.rise && pe.master_reset_n) [*7];
  endsequence

  sequence s_double_fall;
    pe.fall && mode_q == RATE_DOUBLE && pe.master_reset_n;
  endsequence

  property p_double_pair;
    @(posedge sys_clk) disable iff (srst)
    s_qual_rise ##1 s_high_stretch ##1 s_double_fall |=> valid_q && fall_q;
  endproperty
  a_double_pair: assert property (p_double_pair) else $error("fall word missed"); // RULE6

  property p_double_fall;
    @(posedge sys_clk) disable iff (srst)
    pe.fall && pe.master_reset_n && mode_q == RATE_DOUBLE && qual_q
      |=> valid_q && fall_q && data_q == $past(pe.data);
  endproperty
  a_double_fall: assert property (p_double_fall) else $error("double fall lost"); // RULE3

  property p_mode_hold;
    @(posedge sys_clk) disable iff (srst)
    pe.master_reset_n |=> mode_q == $past(mode_q);
  endproperty
  a_mode_hold: assert property (p_mode_hold) else $error("rate changed"); // RULE2

  property p_mode_take;
    @(posedge sys_clk) disable iff (srst)
    !pe.master_reset_n |=> mode_q == rate_t'($past(pe.double_rate_select));
  endproperty
  a_mode_take: assert property (p_mode_take) else $error("rate not taken"); // RULE2

  // ************************************************************
  // refusal and hold checks
  // ************************************************************
  property p_edge_only;
    @(posedge sys_clk) disable iff (srst)
    !pe.rise && !pe.fall |=> !valid_q;
  endproperty
  a_edge_only: assert property (p_edge_only) else $error("word without edge"); // RULE1

  property p_unqual_fall;
    @(posedge sys_clk) disable iff (srst)
    pe.fall && !qual_q |=> !valid_q;
  endproperty
  a_unqual_fall: assert property (p_unqual_fall) else $error("late fall word"); // RULE6

  property p_mreset_quiet;
    @(posedge sys_clk) disable iff (srst)
    !pe.master_reset_n |=> !valid_q;
  endproperty
  a_mreset_quiet: assert property (p_mreset_quiet) else $error("word in reset"); // RULE2

  property p_qual_cleared;
    @(posedge sys_clk) disable iff (srst)
    !pe.master_reset_n |=> !qual_q;
  endproperty
  a_qual_cleared: assert property (p_qual_cleared) else $error("qualifier kept"); // RULE6

  property p_mreset_flag;
    @(posedge sys_clk) disable iff (srst)
    !pe.master_reset_n |=> in_master_reset;
  endproperty
  a_mreset_flag: assert property (p_mreset_flag) else $error("reset flag low"); // RULE2

  property p_mreset_clear;
    @(posedge sys_clk) disable iff (srst)
    pe.master_reset_n |=> !in_master_reset;
  endproperty
  a_mreset_clear: assert property (p_mreset_clear) else $error("reset flag stuck"); // RULE2

  property p_word_hold;
    @(posedge sys_clk) disable iff (srst)
    !valid_q && !$past(srst) |-> data_q == $past(data_q) && fall_q == $past(fall_q);
  endproperty
  a_word_hold: assert property (p_word_hold) else $error("word changed"); // RULE1

endmodule : queue_write_port_capture

/* verilog/wcap_defs.svh */
// constants for the write port capture block
`ifndef WCAP_DEFS_SVH
`define WCAP_DEFS_SVH

// ************************************************************
// reset values and sizes
// ************************************************************
`define WCAP_DATA_W 40
`define WCAP_MODE_RST 1'b0
`define WCAP_CLK_RST 1'b0
`define WCAP_EN_N_RST 1'b1
`define WCAP_MRST_N_RST 1'b0

`endif

/* verilog/wcap_pkg.sv */
// types for the write port capture block
package wcap_pkg;

  // ************************************************************
  // write port rate
  // ************************************************************
  typedef enum logic {
    RATE_SINGLE = 1'b0,
    RATE_DOUBLE = 1'b1
  } rate_t;

endpackage : wcap_pkg
